// *** hssp_params.svh ***
/*
 * Constants of the status and set-parameters command interpreter.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef HSSP_PARAMS_SVH
`define HSSP_PARAMS_SVH

`define HSSP_REPORT_BYTES   64
`define HSSP_IDX_BITS       6
`define HSSP_CMD_CODE       8'h10
`define HSSP_IDX_CODE       6'h00
`define HSSP_IDX_CANCEL     6'h02
`define HSSP_IDX_SPEED      6'h03
`define HSSP_IDX_DIV        6'h04
`define HSSP_IDX_STATE      6'h08
`define HSSP_IDX_REQ_LO     6'h09
`define HSSP_IDX_REQ_HI     6'h0A
`define HSSP_IDX_DONE_LO    6'h0B
`define HSSP_IDX_DONE_HI    6'h0C
`define HSSP_IDX_TIMEOUT    6'h0D
`define HSSP_SUB_CANCEL     8'h10
`define HSSP_SUB_SPEED      8'h20
`define HSSP_RSP_OK         8'h00
`define HSSP_RSP_NONE       8'h00
`define HSSP_RSP_CANCEL_MK  8'h10
`define HSSP_RSP_CANCEL_IDL 8'h11
`define HSSP_RSP_SPEED_OK   8'h20
`define HSSP_RSP_SPEED_NO   8'h21
`define HSSP_DIV_RESET      8'h1B

`endif

// *** hssp_pkg.sv ***
/*
 * Types shared by the command interpreter modules.
 * Assumes the constants header is on the include path.
 */
package hssp_pkg;
    `include "hssp_params.svh"

    typedef logic [7:0] hssp_byte_t;

    typedef enum logic [1:0] {
        HSSP_IDLE,
        HSSP_RECV,
        HSSP_EXEC,
        HSSP_SEND
    } hssp_state_t;
endpackage

// *** hssp_rsp_if.sv ***
/*
 * Carries the latched command results from the interpreter to the
 * response builder. Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface hssp_rsp_if;
    import hssp_pkg::*;
    hssp_byte_t cancelRes;   // Cancel result code
    hssp_byte_t speedRes;    // Speed result code
    hssp_byte_t divEcho;     // Divider echo or zero
    modport ctl (output cancelRes, output speedRes, output divEcho);
    modport bld (input cancelRes, input speedRes, input divEcho);
endinterface

// *** hssp_rsp_mux.sv ***
/*
 * Selects one response byte by index from latched results and live
 * engine status. Assumes the index is valid during the send phase.
 */
`timescale 1ns/1ps
`include "hssp_params.svh"
module hssp_rsp_mux (
    hssp_rsp_if.bld          res,          // Latched command results
    input  wire logic [5:0]  idx,          // Response byte index
    input  wire logic [7:0]  engState,     // Engine state value
    input  wire logic [15:0] reqLen,       // Requested transfer length
    input  wire logic [15:0] doneLen,      // Bytes already transferred
    input  wire logic        timeoutFlag,  // Engine saw a timeout
    output logic [7:0]       byteOut       // Selected byte
);
    import hssp_pkg::*;

    // Fixed layout; unlisted bytes read as zero
    always_comb begin
        case (idx)
            `HSSP_IDX_CODE:    byteOut = `HSSP_CMD_CODE;
            6'h01:             byteOut = `HSSP_RSP_OK;
            `HSSP_IDX_CANCEL:  byteOut = res.cancelRes;
            `HSSP_IDX_SPEED:   byteOut = res.speedRes;
            `HSSP_IDX_DIV:     byteOut = res.divEcho;
            `HSSP_IDX_STATE:   byteOut = engState;
            `HSSP_IDX_REQ_LO:  byteOut = reqLen[7:0];
            `HSSP_IDX_REQ_HI:  byteOut = reqLen[15:8];
            `HSSP_IDX_DONE_LO: byteOut = doneLen[7:0];
            `HSSP_IDX_DONE_HI: byteOut = doneLen[15:8];
            `HSSP_IDX_TIMEOUT: byteOut = {7'h00, timeoutFlag};
            default:           byteOut = 8'h00;
        endcase
    end
endmodule // hssp_rsp_mux

// *** hssp_status_set_params.sv ***
/*
 * Status and set-parameters command interpreter. Takes a command report of
 * up to 64 bytes one byte per cycle, acts on cancel and speed sub-commands, then
 * sends a 64-byte response report unless byte 0 is foreign. Assumes the host stream is synchronous
 * to clock and that the I2C engine samples cancel and divider on clock.
 */
//
// Contract
// - Exchange 64-byte reports, command then response
// - Byte 0 value 0x10 selects this command
// - Every response carries current device status
// - Byte 2 = 0x10 cancels transfer, frees bus
// - Status reports transfer timeouts
// - Byte 3 = 0x20 loads byte 4 divider
// - Divider byte ignored without speed code
// - Response echoes 0x10, then 0x00
// - Cancel result 0x10 marked, 0x11 idle
// - Speed result 0x20 accepted, 0x21 refused
`timescale 1ns/1ps
// Included here as well, so the macros never depend on compile order
`include "hssp_params.svh"
module hssp_status_set_params (
    input  wire logic              clock,        // 200 MHz clock
    input  wire logic              rst,          // Sync reset, high
    input  wire hssp_pkg::hssp_byte_t cmdData,   // Command byte
    input  wire logic              cmdValid,     // Command byte valid
    output logic                   cmdReady,     // Interpreter takes bytes
    input  wire logic              cmdLast,      // Last byte of report
    output hssp_pkg::hssp_byte_t   rspData,      // Response byte
    output logic                   rspValid,     // Response byte valid
    input  wire logic              rspReady,     // Host takes byte
    output logic                   rspLast,      // Last response byte
    output logic                   cmdIgnored,   // Pulse: foreign code
    input  wire logic              engBusy,      // Transfer in progress
    input  wire logic              engTimeout,   // Engine timeout seen
    input  wire hssp_pkg::hssp_byte_t engState,  // Engine state value
    input  wire logic [15:0]       engReqLen,    // Requested length
    input  wire logic [15:0]       engDoneLen,   // Transferred length
    output logic                   engCancel,    // Pulse: abort, free bus
    output logic                   divLoad,      // Pulse: new divider
    output hssp_pkg::hssp_byte_t   divValue      // Active clock divider
);
    import hssp_pkg::*;

    hssp_rsp_if  res ();

    hssp_state_t state_r;
    hssp_state_t state_nxt;
    logic [5:0]  idx_r;
    logic        codeOk_r;
    hssp_byte_t  cancelSub_r;
    hssp_byte_t  speedSub_r;
    hssp_byte_t  divByte_r;
    hssp_byte_t  cancelRes_r;
    hssp_byte_t  speedRes_r;
    hssp_byte_t  divEcho_r;
    hssp_byte_t  divValue_r;
    logic        engCancel_r;
    logic        divLoad_r;
    logic        cmdIgnored_r;
    hssp_byte_t  rspByte;
    hssp_byte_t  cancelRes_nxt;
    hssp_byte_t  speedRes_nxt;
    hssp_byte_t  divEcho_nxt;

    // Decode of the captured report
    wire cmdTake    = cmdValid && cmdReady;
    wire rspTake    = rspValid && rspReady;
    wire lastIdx    = (idx_r == 6'h3F);
    wire cmdEnd     = cmdTake && (cmdLast || lastIdx);
    wire wantCancel = (cancelSub_r == `HSSP_SUB_CANCEL);
    wire wantSpeed  = (speedSub_r == `HSSP_SUB_SPEED);
    // Byte 0 is judged live, since a one-byte report ends at once
    wire codeHit    = (cmdData == `HSSP_CMD_CODE);

    // Handshakes are combinational from the state
    assign cmdReady = (state_r == HSSP_IDLE) || (state_r == HSSP_RECV);
    assign rspValid = (state_r == HSSP_SEND);
    assign rspLast  = rspValid && lastIdx;
    assign rspData  = rspByte;
    assign engCancel  = engCancel_r;
    assign divLoad    = divLoad_r;
    assign divValue   = divValue_r;
    assign cmdIgnored = cmdIgnored_r;

    assign res.cancelRes = cancelRes_r;
    assign res.speedRes  = speedRes_r;
    assign res.divEcho   = divEcho_r;

    // Next state; a foreign report is swallowed with no response
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            HSSP_IDLE: begin
                // Without this a one-byte report would leave us in RECV
                // waiting for bytes that never come
                if (cmdEnd) begin
                    state_nxt = codeHit ? HSSP_EXEC : HSSP_IDLE;
                end else if (cmdTake) begin
                    state_nxt = HSSP_RECV;
                end
            end
            HSSP_RECV: begin
                if (cmdEnd) begin
                    state_nxt = codeOk_r ? HSSP_EXEC : HSSP_IDLE;
                end
            end
            HSSP_EXEC: begin
                state_nxt = HSSP_SEND;
            end
            HSSP_SEND: begin
                if (rspTake && lastIdx) begin
                    state_nxt = HSSP_IDLE;
                end
            end
            default: begin
                state_nxt = HSSP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) state_r <= HSSP_IDLE;
        else     state_r <= state_nxt;
    end

    // Byte index walks the report in both directions
    always_ff @(posedge clock) begin
        if (rst)                                         idx_r <= 6'h00;
        else if (state_r == HSSP_EXEC)                   idx_r <= 6'h00;
        else if (cmdEnd)                                 idx_r <= 6'h00;
        else if (cmdTake || (rspTake && !lastIdx))       idx_r <= idx_r + 6'h01;
        else if (rspTake)                                idx_r <= 6'h00;
    end

    // Capture only bytes 0, 2, 3, 4; all others fall away
    wire atCode   = (state_r == HSSP_IDLE);
    wire atCancel = cmdTake && (idx_r == `HSSP_IDX_CANCEL);
    wire atSpeed  = cmdTake && (idx_r == `HSSP_IDX_SPEED);
    wire atDiv    = cmdTake && (idx_r == `HSSP_IDX_DIV);

    always_ff @(posedge clock) begin
        if (rst) begin
            codeOk_r    <= 1'b0;
            cancelSub_r <= 8'h00;
            speedSub_r  <= 8'h00;
            divByte_r   <= 8'h00;
        end else begin
            if (atCode && cmdTake) begin
                codeOk_r    <= codeHit;
                cancelSub_r <= 8'h00;
                speedSub_r  <= 8'h00;
                divByte_r   <= 8'h00;
            end
            if (atCancel) cancelSub_r <= cmdData;
            if (atSpeed)  speedSub_r  <= cmdData;
            if (atDiv)    divByte_r   <= cmdData;
        end
    end

    // A foreign code is flagged where the report ends; a one-byte report
    // ends while still idle, so byte 0 is judged directly there
    wire endBadIdle = cmdEnd && (state_r == HSSP_IDLE) && !codeHit;
    wire endBadRecv = cmdEnd && (state_r == HSSP_RECV) && !codeOk_r;
    always_ff @(posedge clock) begin
        if (rst) cmdIgnored_r <= 1'b0;
        else     cmdIgnored_r <= endBadIdle || endBadRecv;
    end

    // Execute decisions; the busy level is taken once, in EXEC, so the
    // result codes and the pulses always agree with each other
    wire exec     = (state_r == HSSP_EXEC);
    wire cancelGo = exec && wantCancel && engBusy;
    wire loadGo   = exec && wantSpeed && !engBusy;

    // Result codes; the echo follows the speed code even when refused
    assign cancelRes_nxt = !wantCancel ? `HSSP_RSP_NONE :
                           engBusy     ? `HSSP_RSP_CANCEL_MK :
                                         `HSSP_RSP_CANCEL_IDL;
    assign speedRes_nxt  = !wantSpeed  ? `HSSP_RSP_NONE :
                           engBusy     ? `HSSP_RSP_SPEED_NO :
                                         `HSSP_RSP_SPEED_OK;
    assign divEcho_nxt   = wantSpeed ? divByte_r : 8'h00;

    // Execute: results latched once so the response stays stable
    always_ff @(posedge clock) begin
        if (rst) begin
            cancelRes_r <= `HSSP_RSP_NONE;
            speedRes_r  <= `HSSP_RSP_NONE;
            divEcho_r   <= 8'h00;
            divValue_r  <= `HSSP_DIV_RESET;
            engCancel_r <= 1'b0;
            divLoad_r   <= 1'b0;
        end else begin
            engCancel_r <= cancelGo;
            divLoad_r   <= loadGo;
            if (exec) begin
                cancelRes_r <= cancelRes_nxt;
                speedRes_r  <= speedRes_nxt;
                divEcho_r   <= divEcho_nxt;
            end
            // Divider moves only with its load pulse, never mid-transfer
            if (loadGo) begin
                divValue_r <= divByte_r;
            end
        end
    end

    // Live status is read during the send, so each poll is current
    hssp_rsp_mux u_mux (
        .res         (res),
        .idx         (idx_r),
        .engState    (engState),
        .reqLen      (engReqLen),
        .doneLen     (engDoneLen),
        .timeoutFlag (engTimeout),
        .byteOut     (rspByte)
    );
endmodule // hssp_status_set_params

// *** hssp_props.sv ***
/* Assertions on the interpreter's top ports.
   Assumes a bind to hssp_status_set_params from the bench. */
`timescale 1ns/1ps
module hssp_props (
    input wire logic                 clock,      // Clock
    input wire logic                 rst,        // Sync reset
    input wire logic                 cmdReady,   // Takes command bytes
    input wire hssp_pkg::hssp_byte_t rspData,    // Response byte
    input wire logic                 rspValid,   // Response valid
    input wire logic                 rspReady,   // Host takes byte
    input wire logic                 rspLast,    // Last response byte
    input wire logic                 cmdIgnored, // Foreign code pulse
    input wire logic                 engCancel,  // Abort pulse
    input wire logic                 divLoad,    // Divider pulse
    input wire hssp_pkg::hssp_byte_t divValue    // Active divider
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Response framing, then the one-cycle controls to the engine
    first_echo_a: assert property ($rose(rspValid) |-> rspData == 8'h10)
        else $error("response does not open with the code");
    exec_gap_a: assert property ($rose(rspValid) |-> $past(!cmdReady))
        else $error("response without an execute cycle");
    dir_excl_a: assert property (!(cmdReady && rspValid))
        else $error("command and response phases overlap");
    rsp_hold_a: assert property (rspValid && !rspReady |=> rspValid && $stable(rspLast))
        else $error("response byte dropped before taken");
    last_free_a: assert property (rspValid && rspReady && rspLast |=> cmdReady && !rspValid)
        else $error("no return to command phase");
    cancel_pulse_a: assert property (engCancel |-> $rose(rspValid) ##1 !engCancel)
        else $error("cancel pulse misplaced");
    load_pulse_a: assert property (divLoad |-> $rose(rspValid) ##1 !divLoad)
        else $error("divider pulse misplaced");
    div_cause_a: assert property (!$stable(divValue) |-> divLoad)
        else $error("divider moved without a load");
    ignore_quiet_a: assert property (cmdIgnored |-> !rspValid ##1 !cmdIgnored)
        else $error("foreign report got a response");
endmodule // hssp_props

// *** hssp_engine_model.sv ***
/* Behavioural bus master engine facing the interpreter.
   Assumes the bench asks for a running transfer on busyReq. */
`timescale 1ns/1ps
module hssp_engine_model (
    input  wire logic        clock,      // Clock
    input  wire logic        rst,        // Sync reset
    input  wire logic        busyReq,    // Bench wants a transfer
    input  wire logic        engCancel,  // Abort pulse
    output logic             engBusy,    // Transfer in progress
    output logic             engTimeout, // Stuck transfer seen
    output logic [7:0]       engState,   // State value
    output logic [15:0]      engReqLen,  // Requested length
    output logic [15:0]      engDoneLen  // Transferred length
);
    logic dropR_r;
    // Bus freed one cycle after a cancel; held until the bench lets go
    always_ff @(posedge clock)
        dropR_r <= (rst || !busyReq) ? 1'b0 : (dropR_r || engCancel);
    // A running transfer here is always a stuck one, so it has timed out
    assign engBusy = busyReq && !dropR_r;
    assign engTimeout = engBusy;
    assign engState = engBusy ? 8'h0C : 8'h00;
    assign engReqLen = 16'h0100;
    assign engDoneLen = 16'h0003;
endmodule // hssp_engine_model

// *** test_hssp_status_set_params.sv ***
/* Self-checking bench for the command interpreter.
   Assumes the engine model and the checker are compiled alongside. */
`timescale 1ns/1ps
module test_hssp_status_set_params;
    import hssp_pkg::*;
    logic clock = 1'b0, rst = 1'b1, cmdValid = 1'b0, cmdLast = 1'b0;
    logic rspReady = 1'b0, busyReq = 1'b0;
    logic cmdReady, rspValid, rspLast, cmdIgnored, engBusy, engTimeout;
    logic engCancel, divLoad;
    logic [15:0] engReqLen, engDoneLen;
    hssp_byte_t cmdData = 8'h00, rspData, engState, divValue, rsp [64];
    hssp_byte_t expDiv = 8'h1B;
    integer seed = 89121;
    int n_mismatch = 0, num_checks = 0, nCancel, nLoad, nLen = 64;

    // 5 ns clock
    always #2.5 clock = ~clock;

    hssp_status_set_params u_dut (.clock(clock), .rst(rst),
        .cmdData(cmdData), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .cmdLast(cmdLast), .rspData(rspData), .rspValid(rspValid),
        .rspReady(rspReady), .rspLast(rspLast), .cmdIgnored(cmdIgnored),
        .engBusy(engBusy), .engTimeout(engTimeout), .engState(engState),
        .engReqLen(engReqLen), .engDoneLen(engDoneLen),
        .engCancel(engCancel), .divLoad(divLoad), .divValue(divValue));
    hssp_engine_model u_eng (.clock(clock), .rst(rst), .busyReq(busyReq),
        .engCancel(engCancel), .engBusy(engBusy), .engTimeout(engTimeout),
        .engState(engState), .engReqLen(engReqLen), .engDoneLen(engDoneLen));

    task check(input logic [7:0] seen, input logic [7:0] want);
        num_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Report of nLen bytes, ended by cmdLast; filler bytes are random since they must not matter
    task send(input hssp_byte_t code, b2, b3, b4);
        for (int i = 0; i < nLen; i++) begin
            cmdData = i == 0 ? code : i == 2 ? b2 : i == 3 ? b3 :
                      i == 4 ? b4 : hssp_byte_t'($random(seed));
            cmdValid = 1'b1;
            cmdLast = (i == nLen - 1);
            @(posedge clock);
            check(cmdReady, 1'b1);
            #1;
        end
        cmdValid = 1'b0;
        cmdLast = 1'b0;
    endtask

    // Takes 64 bytes with random host stalls, counting engine pulses
    task recv;
        int k;
        k = 0;
        nCancel = 0;
        nLoad = 0;
        for (int t = 0; t < 600 && k < 64; t++) begin
            rspReady = ($random(seed) % 3) != 0;
            @(posedge clock);
            nCancel += engCancel;
            nLoad += divLoad;
            if (rspValid && rspReady) begin
                rsp[k] = rspData;
                check(rspLast, k == 63);
                k++;
            end
            #1;
        end
        rspReady = 1'b0;
        if (k < 64) begin
            n_mismatch++;
            report_and_stop;
        end
    endtask

    function hssp_byte_t exp_rsp(int k, logic bz, hssp_byte_t b2, b3, b4);
        logic cx, sx;
        cx = b2 == 8'h10;
        sx = b3 == 8'h20;
        case (k)
            0: return 8'h10;
            2: return !cx ? 8'h00 : bz ? 8'h10 : 8'h11;
            3: return !sx ? 8'h00 : bz ? 8'h21 : 8'h20;
            4: return sx ? b4 : 8'h00;
            8: return (bz && !cx) ? 8'h0C : 8'h00;
            10: return 8'h01;
            11: return 8'h03;
            13: return {7'h00, bz && !cx};
            default: return 8'h00;
        endcase
    endfunction

    // Corner cases first, then random sub-codes and busy state, with a foreign code every seventh report
    initial begin
        hssp_byte_t b2, b3, b4, code;
        logic bz;
        int ign, vis;
        repeat (3) @(posedge clock);
        #1 rst = 1'b0;
        check(divValue, 8'h1B);
        for (int s = 0; s < 30; s++) begin
            bz = $random(seed);
            b2 = ($random(seed) & 1) ? 8'h10 : $random(seed);
            b3 = ($random(seed) & 1) ? 8'h20 : $random(seed);
            b4 = $random(seed);
            code = (s % 7 == 3) ? 8'h11 : 8'h10;
            // Short reports: one foreign byte, and one cut before byte 3
            nLen = (s == 3) ? 1 : (s == 4) ? 3 : 64;
            if (s == 4)
                b3 = 8'h20;
            if (s < 2) begin
                bz = s[0];
                b2 = 8'h10;
                b3 = 8'h20;
            end
            if (s == 2) begin
                b2 = 8'h11;
                b3 = 8'h21;
            end
            busyReq = bz;
            @(posedge clock);
            #1;
            send(code, b2, b3, b4);
            // Byte 3 never went out, so no speed code reached the device
            if (s == 4)
                b3 = 8'h00;
            if (code != 8'h10) begin
                ign = 0;
                vis = 0;
                repeat (10) begin
                    @(posedge clock);
                    ign += cmdIgnored;
                    vis += rspValid;
                    #1;
                end
                check(ign, 1);
                check(vis, 0);
            end else begin
                recv;
                for (int k = 0; k < 64; k++)
                    check(rsp[k], exp_rsp(k, bz, b2, b3, b4));
                check(nCancel, bz && b2 == 8'h10);
                check(nLoad, !bz && b3 == 8'h20);
                if (!bz && b3 == 8'h20)
                    expDiv = b4;
                check(divValue, expDiv);
            end
            busyReq = 1'b0;
            @(posedge clock);
            #1;
        end
        report_and_stop;
    end
endmodule // test_hssp_status_set_params

bind hssp_status_set_params hssp_props u_props (.clock(clock), .rst(rst),
    .cmdReady(cmdReady), .rspData(rspData), .rspValid(rspValid),
    .rspReady(rspReady), .rspLast(rspLast), .cmdIgnored(cmdIgnored),
    .engCancel(engCancel), .divLoad(divLoad), .divValue(divValue));
